//--- design/rx_full_pkg.sv
// Shared constants and types for the receive-buffer-full flag block
package rx_full_pkg;

   // ***************************************************
   // Sizes
   // ***************************************************
   localparam int unsigned BUFFER_COUNT = 32;
   localparam int unsigned REG_WIDTH = 16;
   localparam int unsigned INDEX_WIDTH = 5;
   localparam int unsigned ADDR_WIDTH = 4;
   localparam int unsigned COUNT_WIDTH = 6;

   // ***************************************************
   // Register offsets (word index on the register port)
   // ***************************************************
   localparam logic [3:0] RX_BUFFER_FULL_LOW_OFS = 4'h0;
   localparam logic [3:0] RX_BUFFER_FULL_HIGH_OFS = 4'h1;
   localparam logic [3:0] IRQ_STATUS_OFS = 4'h2;
   localparam logic [3:0] IRQ_MASK_OFS = 4'h3;
   localparam logic [3:0] FULL_COUNT_OFS = 4'h4;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int unsigned LOW_FIRST_BUFFER = 0;
   localparam int unsigned HIGH_FIRST_BUFFER = 16;
   localparam int unsigned STAT_FILLED_BIT = 0;
   localparam int unsigned STAT_OVERRUN_BIT = 1;
   localparam int unsigned STAT_WIDTH = 2;

   // ***************************************************
   // Values after reset
   // ***************************************************
   localparam logic [15:0] RX_BUFFER_FULL_RESET = 16'h0000;
   localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
   localparam logic [15:0] READ_DATA_RESET = 16'h0000;

   // ***************************************************
   // Carriers
   // ***************************************************
   typedef struct packed {
      logic valid;
      logic [4:0] index;
   } fill_req_s;

endpackage : rx_full_pkg

//--- design/sticky_flag_bank.sv
// Bank of sticky flags: hardware set, selective clear, set wins
`timescale 1ns/100ps
module sticky_flag_bank
   import rx_full_pkg::*;
#(
   parameter int unsigned WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [WIDTH-1:0] set_in,
   input wire logic [WIDTH-1:0] clear_in,
   output logic [WIDTH-1:0] flags_out
);

   // Refused while elaborating, so a bad width never reaches a netlist
   if (WIDTH < 1) begin : g_bad_width
      $error("sticky_flag_bank: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] flags_q;
   logic [WIDTH-1:0] flags_d;

   // ***************************************************
   // One cell per flag
   // ***************************************************
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_cell
         always_comb begin
            // A set in the same cycle as a clear is kept, not lost
            if (set_in[g]) begin
               flags_d[g] = 1'b1;
            end else if (clear_in[g]) begin
               flags_d[g] = 1'b0;
            end else begin
               flags_d[g] = flags_q[g];
            end
         end

         always_ff @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
               flags_q[g] <= RESET_VALUE[g];
            end else if (ce_in) begin
               flags_q[g] <= flags_d[g];
            end
         end
      end
   endgenerate

   assign flags_out = flags_q;

endmodule : sticky_flag_bank

//--- design/can_rx_buffer_full_flags.sv
// Receive-buffer-full flags with register port and interrupt
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module can_rx_buffer_full_flags
   import rx_full_pkg::*;
#(
   parameter int unsigned DATA_WIDTH = REG_WIDTH
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire fill_req_s fill_in,
   input wire logic [ADDR_WIDTH-1:0] addr_in,
   input wire logic [DATA_WIDTH-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [DATA_WIDTH-1:0] rdata_out,
   output logic [BUFFER_COUNT-1:0] full_flags_out,
   output logic irq_out
);

   // Register map is laid out for 16-bit words only
   if (DATA_WIDTH != REG_WIDTH) begin : g_bad_data_width
      $error("can_rx_buffer_full_flags: DATA_WIDTH must equal 16");
   end

   // ***************************************************
   // Address decode
   // ***************************************************
   logic wr_low;
   logic wr_high;
   logic wr_status;
   logic wr_mask;

   always_comb begin
      wr_low = wr_in && (addr_in == RX_BUFFER_FULL_LOW_OFS);
      wr_high = wr_in && (addr_in == RX_BUFFER_FULL_HIGH_OFS);
      wr_status = wr_in && (addr_in == IRQ_STATUS_OFS);
      wr_mask = wr_in && (addr_in == IRQ_MASK_OFS);
   end

   // ***************************************************
   // Full flags
   // ***************************************************
   logic [BUFFER_COUNT-1:0] fill_set;
   logic [BUFFER_COUNT-1:0] full_clear;
   logic [BUFFER_COUNT-1:0] full_flags;

   always_comb begin
      fill_set = '0;
      if (fill_in.valid) begin
         fill_set[fill_in.index] = 1'b1;
      end
      // Zero bits clear, one bits are ignored
      full_clear = '0;
      if (wr_low) begin
         full_clear[LOW_FIRST_BUFFER +: REG_WIDTH] = ~wdata_in;
      end
      if (wr_high) begin
         full_clear[HIGH_FIRST_BUFFER +: REG_WIDTH] = ~wdata_in;
      end
   end

   sticky_flag_bank #(
      .WIDTH(BUFFER_COUNT),
      .RESET_VALUE({RX_BUFFER_FULL_RESET, RX_BUFFER_FULL_RESET})
   ) u_full_bank (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .set_in(fill_set),
      .clear_in(full_clear),
      .flags_out(full_flags)
   );

   assign full_flags_out = full_flags;

   // ***************************************************
   // Occupancy count
   // ***************************************************
   logic [COUNT_WIDTH-1:0] full_count;

   always_comb begin
      full_count = '0;
      for (int i = 0; i < BUFFER_COUNT; i++) begin
         full_count = full_count + COUNT_WIDTH'(full_flags[i]);
      end
   end

   // ***************************************************
   // Interrupt status and mask
   // ***************************************************
   // Overrun: a fill lands on a buffer software has not yet released
   logic [STAT_WIDTH-1:0] stat_set;
   logic [STAT_WIDTH-1:0] stat_clear;
   logic [STAT_WIDTH-1:0] irq_status;
   logic [STAT_WIDTH-1:0] irq_mask_q;
   logic [STAT_WIDTH-1:0] irq_mask_d;

   always_comb begin
      stat_set = '0;
      stat_set[STAT_FILLED_BIT] = fill_in.valid;
      stat_set[STAT_OVERRUN_BIT] = fill_in.valid && full_flags[fill_in.index];
      stat_clear = wr_status ? wdata_in[STAT_WIDTH-1:0] : '0;
      irq_mask_d = wr_mask ? wdata_in[STAT_WIDTH-1:0] : irq_mask_q;
   end

   sticky_flag_bank #(
      .WIDTH(STAT_WIDTH),
      .RESET_VALUE(IRQ_STATUS_RESET)
   ) u_status_bank (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .set_in(stat_set),
      .clear_in(stat_clear),
      .flags_out(irq_status)
   );

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_mask_q <= IRQ_MASK_RESET;
      end else if (ce_in) begin
         irq_mask_q <= irq_mask_d;
      end
   end

   assign irq_out = |(irq_status & irq_mask_q);

   // ***************************************************
   // Read data
   // ***************************************************
   // Data stands from the first enabled edge after the strobe until the next enabled edge, zero otherwise
   logic [DATA_WIDTH-1:0] rdata_q;
   logic [DATA_WIDTH-1:0] rdata_d;

   always_comb begin
      rdata_d = READ_DATA_RESET;
      if (rd_in) begin
         unique case (addr_in)
            RX_BUFFER_FULL_LOW_OFS: begin
               rdata_d = full_flags[LOW_FIRST_BUFFER +: REG_WIDTH];
            end
            RX_BUFFER_FULL_HIGH_OFS: begin
               rdata_d = full_flags[HIGH_FIRST_BUFFER +: REG_WIDTH];
            end
            IRQ_STATUS_OFS: begin
               rdata_d[STAT_WIDTH-1:0] = irq_status;
            end
            IRQ_MASK_OFS: begin
               rdata_d[STAT_WIDTH-1:0] = irq_mask_q;
            end
            FULL_COUNT_OFS: begin
               rdata_d[COUNT_WIDTH-1:0] = full_count;
            end
            default: begin
               rdata_d = READ_DATA_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_q <= READ_DATA_RESET;
      end else if (ce_in) begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata_out = rdata_q;

endmodule : can_rx_buffer_full_flags

//--- test/can_rx_buffer_full_flags_checker.sv
// Port checker for the receive-buffer-full flag block
`timescale 1ns/100ps
module can_rx_buffer_full_flags_checker
   import rx_full_pkg::*;
#(
   parameter int unsigned DATA_WIDTH = REG_WIDTH
) (
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire fill_req_s fill_in,
   input wire logic [ADDR_WIDTH-1:0] addr_in,
   input wire logic [DATA_WIDTH-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [DATA_WIDTH-1:0] rdata_out,
   input wire logic [BUFFER_COUNT-1:0] full_flags_out,
   input wire logic irq_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   sequence rd_low;
      ce_in && rd_in && addr_in == RX_BUFFER_FULL_LOW_OFS;
   endsequence
   sequence rd_high;
      ce_in && rd_in && addr_in == RX_BUFFER_FULL_HIGH_OFS;
   endsequence
   AST_FILL_SETS: assert property (ce_in && fill_in.valid |=> full_flags_out[$past(fill_in.index)])
      else $error("fill did not set its flag");
   AST_ONLY_SW_CLEARS: assert property (|($past(full_flags_out) & ~full_flags_out) |->
      $past(ce_in && wr_in && addr_in < 4'h2)) else $error("flag cleared without a write");
   AST_WRITE_NEVER_SETS: assert property (|(full_flags_out & ~$past(full_flags_out)) |->
      $past(ce_in && fill_in.valid)) else $error("flag set without a fill");
   AST_RESET_ZERO: assert property (disable iff (1'b0) rst_in |=>
      full_flags_out == '0 && !irq_out && rdata_out == '0) else $error("outputs not clear in reset");
   AST_LOW_MAP: assert property (rd_low |=> rdata_out == $past(full_flags_out[15:0]))
      else $error("low register map wrong");
   AST_HIGH_MAP: assert property (rd_high |=> rdata_out == $past(full_flags_out[31:16]))
      else $error("high register map wrong");
   AST_ONES_KEEP: assert property (ce_in && wr_in && wdata_in == 16'hFFFF && !fill_in.valid
      |=> $stable(full_flags_out)) else $error("writing ones changed flags");
   AST_RDATA_IDLE: assert property (ce_in && !rd_in |=> rdata_out == '0)
      else $error("read data not idle");
endmodule : can_rx_buffer_full_flags_checker

bind can_rx_buffer_full_flags can_rx_buffer_full_flags_checker #(.DATA_WIDTH(DATA_WIDTH)) chk_i (.*);

//--- test/tb.sv
// Self-checking bench for the receive-buffer-full flag block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module tb;
   import rx_full_pkg::*;
   logic mclk_in, rst_in, ce_in, wr_in, rd_in, irq_out;
   fill_req_s fill_in;
   logic [3:0] addr_in;
   logic [15:0] wdata_in, rdata_out;
   logic [31:0] full_flags_out;
   int n_fail = 0;
   int checks = 0;
   can_rx_buffer_full_flags can_rx_buffer_full_flags_i (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
      .fill_in(fill_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .full_flags_out(full_flags_out), .irq_out(irq_out));
   // ***************************
   // Bus and fill tasks
   // ***************************
   task op(input logic w, r, f, input logic [3:0] a, input logic [15:0] d, input logic [4:0] i);
      @(posedge mclk_in);
      wr_in <= w;
      rd_in <= r;
      addr_in <= a;
      wdata_in <= d;
      fill_in <= '{f, i};
      @(posedge mclk_in);
      wr_in <= 1'b0;
      rd_in <= 1'b0;
      fill_in <= '{1'b0, 5'h00};
      #1;
   endtask : op
   task rd(input logic [3:0] a, output logic [15:0] v);
      op(1'b0, 1'b1, 1'b0, a, 16'h0000, 5'h00);
      v = rdata_out;
   endtask : rd
   task done_msg(input string s);
      $display("Test %s finished, mismatches %0d", s, n_fail);
   endtask : done_msg
   task test_done;
      $display("Comparisons %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : test_done
   // ***************************
   // Scenarios
   // ***************************
   task t_reset;
      logic [15:0] v;
      rd(4'h0, v); `CHK(v, 16'h0000)
      rd(4'h1, v); `CHK(v, 16'h0000)
      `CHK(full_flags_out, 32'h0000_0000)
      `CHK(irq_out, 1'b0)
      done_msg("reset");
   endtask : t_reset
   task t_map;
      logic [15:0] v;
      foreach (v[k]) op(1'b0, 1'b0, k % 15 == 0, 4'h0, 16'h0, 5'(k));
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd17);
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd31);
      `CHK(full_flags_out, 32'h8002_8001)
      rd(4'h0, v); `CHK(v, 16'h8001)
      rd(4'h1, v); `CHK(v, 16'h8002)
      rd(4'h4, v); `CHK(v, 16'h0004)
      rd(4'hF, v); `CHK(v, 16'h0000)
      done_msg("map");
   endtask : t_map
   task t_clear;
      logic [15:0] v;
      op(1'b1, 1'b0, 1'b0, 4'hF, 16'h0000, 5'h00);
      `CHK(full_flags_out, 32'h8002_8001)
      op(1'b1, 1'b0, 1'b0, 4'h0, 16'hFFFE, 5'h00);
      rd(4'h0, v); `CHK(v, 16'h8000)
      op(1'b1, 1'b0, 1'b0, 4'h1, 16'hFFFF, 5'h00);
      rd(4'h1, v); `CHK(v, 16'h8002)
      op(1'b1, 1'b0, 1'b0, 4'h0, 16'hFFFF, 5'h00);
      `CHK(full_flags_out, 32'h8002_8000)
      op(1'b1, 1'b0, 1'b0, 4'h1, 16'hFFFD, 5'h00);
      `CHK(full_flags_out, 32'h8000_8000)
      op(1'b1, 1'b0, 1'b0, 4'h1, 16'h0000, 5'h00);
      `CHK(full_flags_out[31:16], 16'h0000)
      done_msg("clear");
   endtask : t_clear
   task t_set_wins;
      op(1'b1, 1'b0, 1'b1, 4'h0, 16'h0000, 5'd3);
      `CHK(full_flags_out, 32'h0000_0008)
      @(posedge mclk_in);
      ce_in <= 1'b0;
      op(1'b1, 1'b0, 1'b1, 4'h0, 16'h0000, 5'd9);
      @(posedge mclk_in);
      ce_in <= 1'b1;
      #1;
      `CHK(full_flags_out, 32'h0000_0008)
      done_msg("set_wins");
   endtask : t_set_wins
   task t_irq;
      logic [15:0] v;
      op(1'b1, 1'b0, 1'b0, 4'h2, 16'h0003, 5'h00);
      op(1'b1, 1'b0, 1'b0, 4'h3, 16'h0001, 5'h00);
      `CHK(irq_out, 1'b0)
      rd(4'h3, v); `CHK(v, 16'h0001)
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd5);
      `CHK(irq_out, 1'b1)
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd5);
      rd(4'h2, v); `CHK(v, 16'h0003)
      op(1'b1, 1'b0, 1'b0, 4'h3, 16'h0000, 5'h00);
      `CHK(irq_out, 1'b0)
      op(1'b1, 1'b0, 1'b0, 4'h2, 16'h0003, 5'h00);
      rd(4'h2, v); `CHK(v, 16'h0000)
      op(1'b1, 1'b0, 1'b0, 4'h3, 16'h0002, 5'h00);
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd7);
      `CHK(irq_out, 1'b0)
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd7);
      `CHK(irq_out, 1'b1)
      done_msg("irq");
   endtask : t_irq
   task t_reset_mid;
      logic [15:0] v;
      @(posedge mclk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      #1;
      `CHK(full_flags_out, 32'h0000_0000)
      `CHK(irq_out, 1'b0)
      rd(4'h3, v); `CHK(v, 16'h0000)
      rd(4'h2, v); `CHK(v, 16'h0000)
      op(1'b0, 1'b0, 1'b1, 4'h0, 16'h0, 5'd1);
      `CHK(full_flags_out, 32'h0000_0002)
      done_msg("reset_mid");
   endtask : t_reset_mid
   initial begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
   initial begin
      {rst_in, ce_in, wr_in, rd_in, addr_in, wdata_in} = {1'b1, 1'b1, 22'h0};
      fill_in = '{1'b0, 5'h00};
      repeat (16) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_reset();
      t_map();
      t_clear();
      t_set_wins();
      t_irq();
      t_reset_mid();
      test_done();
   end
endmodule : tb
